// file: core/pmr_accum.sv
// Wrapping accumulator with overflow pulse, unsigned or two's complement
`timescale 1ns/1ps
`default_nettype none
module pmr_accum #(
	parameter int W = 40,
	parameter int IN_W = 24,
	parameter bit SIGNED = 1'b0
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Synchronous reset
	input wire logic add_i, // Add increment this cycle
	input wire logic [IN_W-1:0] inc_i, // Increment
	output logic [W-1:0] acc_o, // Accumulated value
	output logic ovf_o // Overflow pulse
);
	generate
		if (W <= IN_W) begin : g_bad_width
			$error("pmr_accum: W must exceed IN_W");
		end
	endgenerate

	logic [W-1:0] acc_q, acc_d;
	logic ovf_q, ovf_d;
	logic [W-1:0] ext;
	logic [W:0] sum;

	always_comb begin
		ext = SIGNED ? W'($signed(inc_i)) : W'(inc_i);
		sum = {1'b0, acc_q} + {1'b0, ext};
		acc_d = acc_q;
		ovf_d = 1'b0;
		if (add_i) begin
			// Wraps rather than saturates; the flag tells software
			acc_d = sum[W-1:0];
			if (SIGNED) begin
				ovf_d = (acc_q[W-1] == ext[W-1]) & (sum[W-1] != acc_q[W-1]);
			end else begin
				ovf_d = sum[W];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			ovf_q <= ovf_d;
		end
	end

	assign acc_o = acc_q;
	assign ovf_o = ovf_q;
endmodule // pmr_accum
`default_nettype wire

// file: core/pmr_monitor_regs.sv
// Result registers, alert logic and interrupt of the power monitor
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bus voltage in bits 23:4, never negative
// - Low four bits of voltage and current results read zero
// - Die temperature fills sixteen bits, signed
// - Current signed in bits 23:4
// - Power unsigned, fills bits 23:0
// - Energy unsigned forty-bit accumulator
// - Charge signed forty-bit accumulator
// - Transparent mode: alert follows fault clearing
// - Latched mode: alert held until diag read
// - Conversion ready drives alert when enabled
// - Compare raw or averaged values per bit
// - Polarity bit selects open-drain active level
// - Latched: done flag clears on read, start
// - Energy overflow flag, cleared by energy read
module pmr_monitor_regs (
	input wire logic clk_i, // Clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte enables
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic conv_start_i, // New triggered conversion starts
	input wire logic raw_valid_i, // Raw sample compared this cycle
	input wire logic [5:0] fault_raw_i, // Limit faults on raw sample
	input wire logic conv_done_i, // Averaged conversion completes
	input wire logic [5:0] fault_avg_i, // Limit faults on averaged value
	input wire logic [19:0] bus_voltage_i, // Bus voltage code
	input wire logic [15:0] die_temp_i, // Die temperature code
	input wire logic [19:0] current_i, // Current code, signed
	input wire logic [23:0] power_i, // Power code, unsigned
	output logic alert_o, // Alert pin output level
	output logic alert_oe_o, // Alert pin output enable
	output logic irq_o // Interrupt, level, active high
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Twenty-bit code into a 24-bit register, low nibble zero
	function automatic logic [31:0] place_result(input logic [19:0] v);
		place_result = {8'h00, v, 4'h0};
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	pmr_reg_if rif ();

	pmr_wb_front u_front (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.rif(rif.front)
	);

	logic diag_rd, energy_rd, charge_rd;
	logic diag_wr, status_wr, mask_wr;

	assign diag_rd = rif.rd_stb & hit(rif.addr, pmr_pkg::ADR_DIAG);
	assign energy_rd = rif.rd_stb & hit(rif.addr, pmr_pkg::ADR_ENERGY);
	assign charge_rd = rif.rd_stb & hit(rif.addr, pmr_pkg::ADR_CHARGE);
	assign diag_wr = rif.wr_stb & hit(rif.addr, pmr_pkg::ADR_DIAG)
		& rif.sel[1];
	assign status_wr = rif.wr_stb & hit(rif.addr, pmr_pkg::ADR_IRQ_STATUS)
		& rif.sel[0];
	assign mask_wr = rif.wr_stb & hit(rif.addr, pmr_pkg::ADR_IRQ_MASK)
		& rif.sel[0];

	// ------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------
	logic [19:0] volt_q, volt_d;
	logic [15:0] temp_q, temp_d;
	logic [19:0] curr_q, curr_d;
	logic [23:0] power_q, power_d;

	always_comb begin
		volt_d = volt_q;
		temp_d = temp_q;
		curr_d = curr_q;
		power_d = power_q;
		if (conv_done_i) begin
			// A negative code is a glitch; bus voltage is clamped at zero
			volt_d = bus_voltage_i[19] ? '0 : bus_voltage_i;
			temp_d = die_temp_i;
			curr_d = current_i;
			power_d = power_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			volt_q <= '0;
			temp_q <= '0;
			curr_q <= '0;
			power_q <= '0;
		end else begin
			volt_q <= volt_d;
			temp_q <= temp_d;
			curr_q <= curr_d;
			power_q <= power_d;
		end
	end

	// ------------------------------------------------------------
	// Energy and charge accumulators
	// ------------------------------------------------------------
	logic [39:0] energy_acc, charge_acc;
	logic energy_ovf, charge_ovf;

	pmr_accum #(
		.W(pmr_pkg::ACC_W),
		.IN_W(pmr_pkg::POWER_W),
		.SIGNED(1'b0)
	) u_energy (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.add_i(conv_done_i),
		.inc_i(power_i),
		.acc_o(energy_acc),
		.ovf_o(energy_ovf)
	);

	pmr_accum #(
		.W(pmr_pkg::ACC_W),
		.IN_W(pmr_pkg::VOLT_W),
		.SIGNED(1'b1)
	) u_charge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.add_i(conv_done_i),
		.inc_i(current_i),
		.acc_o(charge_acc),
		.ovf_o(charge_ovf)
	);

	// ------------------------------------------------------------
	// Diagnostic and alert control
	// ------------------------------------------------------------
	logic latch_en_q, latch_en_d;
	logic conversion_ready_alert_enable_en_q, conversion_ready_alert_enable_en_d;
	logic avg_cmp_q, avg_cmp_d;
	logic pol_q, pol_d;
	logic [5:0] flags_q, flags_d;
	logic done_q, done_d;
	logic eof_q, eof_d;
	logic cof_q, cof_d;
	logic cmp_valid;
	logic [5:0] cmp_fault;
	logic done_clr;
	logic alert_act;

	always_comb begin
		latch_en_d = latch_en_q;
		conversion_ready_alert_enable_en_d = conversion_ready_alert_enable_en_q;
		avg_cmp_d = avg_cmp_q;
		pol_d = pol_q;
		if (diag_wr) begin
			latch_en_d = rif.wdata[pmr_pkg::DIAG_LATCH];
			conversion_ready_alert_enable_en_d = rif.wdata[pmr_pkg::DIAG_CONVERSION_READY_ALERT_ENABLE];
			avg_cmp_d = rif.wdata[pmr_pkg::DIAG_AVG];
			pol_d = rif.wdata[pmr_pkg::DIAG_POL];
		end
	end

	always_comb begin
		// Averaged compare delays the alert to the end of averaging
		cmp_valid = avg_cmp_q ? conv_done_i : raw_valid_i;
		cmp_fault = avg_cmp_q ? fault_avg_i : fault_raw_i;
		flags_d = flags_q;
		if (latch_en_q) begin
			// A fault seen in the read cycle survives the read
			flags_d = diag_rd ? '0 : flags_q;
			if (cmp_valid) begin
				flags_d = flags_d | cmp_fault;
			end
		end else if (cmp_valid) begin
			flags_d = cmp_fault;
		end
	end

	always_comb begin
		done_clr = conv_start_i | (latch_en_q & diag_rd);
		done_d = conv_done_i | (done_q & ~done_clr);
		eof_d = energy_ovf | (eof_q & ~energy_rd);
		cof_d = charge_ovf | (cof_q & ~charge_rd);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_en_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_LATCH];
			conversion_ready_alert_enable_en_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_CONVERSION_READY_ALERT_ENABLE];
			avg_cmp_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_AVG];
			pol_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_POL];
			flags_q <= '0;
			done_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_DONE];
			eof_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_EOF];
			cof_q <= pmr_pkg::DIAG_RESET[pmr_pkg::DIAG_COF];
		end else begin
			latch_en_q <= latch_en_d;
			conversion_ready_alert_enable_en_q <= conversion_ready_alert_enable_en_d;
			avg_cmp_q <= avg_cmp_d;
			pol_q <= pol_d;
			flags_q <= flags_d;
			done_q <= done_d;
			eof_q <= eof_d;
			cof_q <= cof_d;
		end
	end

	// ------------------------------------------------------------
	// Alert pin
	// ------------------------------------------------------------
	logic alert_oe_q, alert_oe_d;
	logic alert_prev_q;

	always_comb begin
		alert_act = (|flags_q) | (conversion_ready_alert_enable_en_q & done_q);
		// Open drain: active low pulls while active, active high while idle
		alert_oe_d = pol_q ? ~alert_act : alert_act;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_oe_q <= 1'b0;
			alert_prev_q <= 1'b0;
		end else begin
			alert_oe_q <= alert_oe_d;
			alert_prev_q <= alert_act;
		end
	end

	// The pin only ever pulls low; level comes from the enable
	assign alert_o = 1'b0;
	assign alert_oe_o = alert_oe_q;

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	logic [3:0] st_q, st_d;
	logic [3:0] mask_q, mask_d;
	logic [3:0] st_ev;
	logic irq_q, irq_d;

	always_comb begin
		st_ev = '0;
		st_ev[pmr_pkg::ST_CONV] = conv_done_i;
		st_ev[pmr_pkg::ST_ALERT] = alert_act & ~alert_prev_q;
		st_ev[pmr_pkg::ST_EOF] = energy_ovf;
		st_ev[pmr_pkg::ST_COF] = charge_ovf;
		st_d = st_q;
		if (status_wr) begin
			st_d = st_q & ~rif.wdata[pmr_pkg::ST_W-1:0];
		end
		// New events win over a clear in the same cycle
		st_d = st_d | st_ev;
		mask_d = mask_wr ? rif.wdata[pmr_pkg::ST_W-1:0] : mask_q;
		irq_d = |(st_d & mask_d);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			st_q <= st_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	assign irq_o = irq_q;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [15:0] diag_word;

	always_comb begin
		diag_word = '0;
		diag_word[pmr_pkg::DIAG_LATCH] = latch_en_q;
		diag_word[pmr_pkg::DIAG_CONVERSION_READY_ALERT_ENABLE] = conversion_ready_alert_enable_en_q;
		diag_word[pmr_pkg::DIAG_AVG] = avg_cmp_q;
		diag_word[pmr_pkg::DIAG_POL] = pol_q;
		diag_word[pmr_pkg::DIAG_EOF] = eof_q;
		diag_word[pmr_pkg::DIAG_COF] = cof_q;
		diag_word[pmr_pkg::FAULT_LSB +: pmr_pkg::FAULT_W] = flags_q;
		diag_word[pmr_pkg::DIAG_DONE] = done_q;
		// Trim memory is not modelled and always reports healthy
		diag_word[pmr_pkg::DIAG_MEM] = 1'b1;
	end

	always_comb begin
		unique case (rif.addr)
			pmr_pkg::ADR_BUS_VOLT: rif.rdata = place_result(volt_q);
			pmr_pkg::ADR_DIE_TEMP: rif.rdata = {16'h0000, temp_q};
			pmr_pkg::ADR_CURRENT: rif.rdata = place_result(curr_q);
			pmr_pkg::ADR_POWER: rif.rdata = {8'h00, power_q};
			pmr_pkg::ADR_ENERGY: rif.rdata = energy_acc[31:0];
			pmr_pkg::ADR_ENERGY_HI: rif.rdata = {24'h00_0000, energy_acc[39:32]};
			pmr_pkg::ADR_CHARGE: rif.rdata = charge_acc[31:0];
			pmr_pkg::ADR_CHARGE_HI: rif.rdata = {24'h00_0000, charge_acc[39:32]};
			pmr_pkg::ADR_DIAG: rif.rdata = {16'h0000, diag_word};
			pmr_pkg::ADR_IRQ_STATUS: rif.rdata = {28'h000_0000, st_q};
			pmr_pkg::ADR_IRQ_MASK: rif.rdata = {28'h000_0000, mask_q};
			default: rif.rdata = 32'h0000_0000;
		endcase
	end

endmodule // pmr_monitor_regs
`default_nettype wire

// file: core/pmr_pkg.sv
// Shared constants of the power monitor result and alert register bank
package pmr_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam int IDX_BUS_VOLT = 'h5;
	localparam int IDX_DIE_TEMP = 'h6;
	localparam int IDX_CURRENT = 'h7;
	localparam int IDX_POWER = 'h8;
	localparam int IDX_ENERGY = 'h9;
	localparam int IDX_CHARGE = 'ha;
	localparam int IDX_DIAG = 'hb;
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_BUS_VOLT = 8'(IDX_BUS_VOLT * 4);
	localparam logic [7:0] ADR_DIE_TEMP = 8'(IDX_DIE_TEMP * 4);
	localparam logic [7:0] ADR_CURRENT = 8'(IDX_CURRENT * 4);
	localparam logic [7:0] ADR_POWER = 8'(IDX_POWER * 4);
	localparam logic [7:0] ADR_ENERGY = 8'(IDX_ENERGY * 4);
	localparam logic [7:0] ADR_CHARGE = 8'(IDX_CHARGE * 4);
	localparam logic [7:0] ADR_DIAG = 8'(IDX_DIAG * 4);
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h30;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h34;
	localparam logic [7:0] ADR_ENERGY_HI = 8'h38;
	localparam logic [7:0] ADR_CHARGE_HI = 8'h3c;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int RES_LSB = 4;
	localparam int VOLT_W = 20;
	localparam int TEMP_W = 16;
	localparam int POWER_W = 24;
	localparam int ACC_W = 40;
	localparam int DIAG_LATCH = 15;
	localparam int DIAG_CONVERSION_READY_ALERT_ENABLE = 14;
	localparam int DIAG_AVG = 13;
	localparam int DIAG_POL = 12;
	localparam int DIAG_EOF = 11;
	localparam int DIAG_COF = 10;
	localparam int FAULT_LSB = 2;
	localparam int FAULT_W = 6;
	localparam int DIAG_DONE = 1;
	localparam int DIAG_MEM = 0;
	localparam int ST_CONV = 0;
	localparam int ST_ALERT = 1;
	localparam int ST_EOF = 2;
	localparam int ST_COF = 3;
	localparam int ST_W = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] DIAG_RESET = 16'h0001;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

endpackage

// file: core/pmr_reg_if.sv
// Register request carrier between bus front end and register bank
`timescale 1ns/1ps
`default_nettype none
interface pmr_reg_if;
	logic rd_stb;
	logic wr_stb;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [3:0] sel;
	logic [31:0] rdata;
	modport front(output rd_stb, output wr_stb, output addr, output wdata,
		output sel, input rdata);
	modport regs(input rd_stb, input wr_stb, input addr, input wdata,
		input sel, output rdata);
endinterface
`default_nettype wire

// file: core/pmr_wb_front.sv
// Classic Wishbone slave front end: one strobe per access, answer next cycle
`timescale 1ns/1ps
`default_nettype none
module pmr_wb_front (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Synchronous reset
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte enables
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	pmr_reg_if.front rif // Register requests
);
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic req;

	// Ack low gates the request so each access strobes exactly once
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign rif.rd_stb = req & ~wb_we_i;
	assign rif.wr_stb = req & wb_we_i;
	assign rif.addr = {wb_adr_i[7:2], 2'b00};
	assign rif.wdata = wb_dat_i;
	assign rif.sel = wb_sel_i;

	always_comb begin
		ack_d = req;
		dat_d = dat_q;
		if (req & ~wb_we_i) begin
			dat_d = rif.rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= pmr_pkg::RESULT_RESET;
		end else begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
endmodule // pmr_wb_front
`default_nettype wire

// file: tb/pmr_meas_model.sv
// Measurement front end model: conversions and compare faults
`timescale 1ns/1ps
`default_nettype none
module pmr_meas_model (
	input wire logic clk_i, // Clock
	output logic start_o, // Conversion start
	output logic raw_o, // Raw compare strobe
	output logic [5:0] fraw_o, // Raw faults
	output logic done_o, // Conversion done
	output logic [5:0] favg_o, // Averaged faults
	output logic [19:0] volt_o, // Bus voltage
	output logic [15:0] temp_o, // Temperature
	output logic [19:0] cur_o, // Current
	output logic [23:0] pow_o // Power
);
	initial begin
		start_o = 1'b0;
		raw_o = 1'b0;
		fraw_o = 6'h00;
		done_o = 1'b0;
		favg_o = 6'h00;
		volt_o = 20'h0;
		temp_o = 16'h0;
		cur_o = 20'h0;
		pow_o = 24'h0;
	end
	// Values invert once no longer valid, so stale sampling shows
	task automatic convert(input logic [19:0] v, input logic [15:0] t,
		input logic [19:0] c, input logic [23:0] p, input logic [5:0] f,
		input int n);
		@(posedge clk_i);
		{volt_o, temp_o, cur_o, pow_o, favg_o} <= {v, t, c, p, f};
		done_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		{volt_o, temp_o, cur_o, pow_o, favg_o} <= ~{v, t, c, p, f};
		done_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic raw(input logic [5:0] f);
		@(posedge clk_i);
		raw_o <= 1'b1;
		fraw_o <= f;
		@(posedge clk_i);
		raw_o <= 1'b0;
		fraw_o <= ~f;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic start();
		@(posedge clk_i);
		start_o <= 1'b1;
		@(posedge clk_i);
		start_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
endmodule // pmr_meas_model
`default_nettype wire

// file: tb/pmr_monitor_regs_props.sv
// Port assertions of the power monitor register bank
`timescale 1ns/1ps
`default_nettype none
module pmr_monitor_regs_props (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire logic conv_start_i, // Start
	input wire logic conv_done_i, // Done
	input wire logic alert_o, // Alert level
	input wire logic alert_oe_o, // Alert enable
	input wire logic irq_o // Interrupt
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic diag_rd;
	logic [3:0] cfg_d;
	logic [3:0] cfg_q;
	assign req = wb_cyc_i && wb_stb_i;
	assign diag_rd = req && !wb_ack_o && !wb_we_i
		&& wb_adr_i == pmr_pkg::ADR_DIAG;
	// Latch, ready, averaging, polarity as last written; one edge late
	always_comb begin
		cfg_d = cfg_q;
		if (req && wb_ack_o && wb_we_i && wb_sel_i[1]
			&& wb_adr_i == pmr_pkg::ADR_DIAG) begin
			cfg_d = wb_dat_i[15:12];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= 4'h0;
		end else begin
			cfg_q <= cfg_d;
		end
	end
	sequence s_rd(logic [7:0] a);
		wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == a;
	endsequence
	property p_rst;
		disable iff (1'b0) rst_i |=> !wb_ack_o && !alert_oe_o && !irq_o;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not idle after reset");
	property p_ack_next;
		req && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("ack not in next cycle");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(req);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_volt;
		s_rd(pmr_pkg::ADR_BUS_VOLT) |-> wb_dat_o[31:23] == 9'h000
			&& wb_dat_o[3:0] == 4'h0;
	endproperty
	a_volt: assert property (p_volt)
		else $error("bus voltage read negative or low bits set");
	property p_cur_low;
		s_rd(pmr_pkg::ADR_CURRENT) |-> wb_dat_o[3:0] == 4'h0;
	endproperty
	a_cur_low: assert property (p_cur_low)
		else $error("current read low bits set");
	property p_temp;
		s_rd(pmr_pkg::ADR_DIE_TEMP) |-> wb_dat_o[31:16] == 16'h0000;
	endproperty
	a_temp: assert property (p_temp)
		else $error("temperature read wider than sixteen bits");
	property p_power;
		s_rd(pmr_pkg::ADR_POWER) |-> wb_dat_o[31:24] == 8'h00;
	endproperty
	a_power: assert property (p_power)
		else $error("power read wider than 24 bits");
	property p_conversion_ready_alert_enable;
		cfg_q[2] && !cfg_q[0] && conv_done_i |-> ##[1:3] alert_oe_o;
	endproperty
	a_conversion_ready_alert_enable: assert property (p_conversion_ready_alert_enable)
		else $error("no alert on conversion ready");
	property p_latch;
		cfg_q[3] && !cfg_q[0] && $past(alert_oe_o) && !$past(diag_rd)
			&& !$past(diag_rd, 2) && !$past(conv_start_i)
			&& !$past(conv_start_i, 2) |-> alert_oe_o;
	endproperty
	a_latch: assert property (p_latch)
		else $error("latched alert dropped without read");
	property p_open;
		alert_o == 1'b0;
	endproperty
	a_open: assert property (p_open)
		else $error("alert pin driven high");
	c_rd: cover property (s_rd(pmr_pkg::ADR_ENERGY));
	c_alert: cover property ($rose(alert_oe_o));
	c_irq: cover property ($rose(irq_o));
endmodule // pmr_monitor_regs_props
bind pmr_monitor_regs pmr_monitor_regs_props u_props (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
	.alert_o(alert_o), .alert_oe_o(alert_oe_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/pmr_monitor_regs_tb_top.sv
// Self-checking bench of the power monitor register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) begin \
			num_errors++; \
			$display("CHECK FAILED %s exp %h seen %h", nm, e, g); \
		end \
	end
module pmr_monitor_regs_tb_top;
	logic clk_i;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'hF;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack, cs, rv, cd, alert, oe, irq, irq0;
	logic [5:0] fr, fa;
	logic [19:0] v, c;
	logic [15:0] t;
	logic [23:0] p;
	logic [40:0] exp_e = 41'h0;
	logic [39:0] exp_c = 40'h0;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	pmr_monitor_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.conv_start_i(cs), .raw_valid_i(rv), .fault_raw_i(fr),
		.conv_done_i(cd), .fault_avg_i(fa), .bus_voltage_i(v),
		.die_temp_i(t), .current_i(c), .power_i(p), .alert_o(alert),
		.alert_oe_o(oe), .irq_o(irq));
	pmr_meas_model u_src (.clk_i(clk_i), .start_o(cs), .raw_o(rv),
		.fraw_o(fr), .done_o(cd), .favg_o(fa), .volt_o(v), .temp_o(t),
		.cur_o(c), .pow_o(p));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Overflow run alone takes some 65600 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, q)
	endtask
	task automatic dg(input logic [31:0] e);
		rd(pmr_pkg::ADR_DIAG, e);
	endtask
	task automatic oe_is(input logic e);
		repeat (2) @(posedge clk_i);
		`CHK("alert_oe", e, oe)
	endtask
	task automatic cv(input logic [5:0] f);
		u_src.convert(20'h0, 16'h0, 20'h0, 24'h0, f, 1);
	endtask
	task automatic conv(input logic [19:0] vv, input logic [15:0] tt,
		input logic [19:0] cc, input logic [23:0] pp);
		u_src.convert(vv, tt, cc, pp, 6'h00, 1);
		exp_e = exp_e + 41'(pp);
		exp_c = exp_c + {{20{cc[19]}}, cc};
		rd(pmr_pkg::ADR_BUS_VOLT, vv[19] ? 32'h0 : {8'h00, vv, 4'h0});
		rd(pmr_pkg::ADR_DIE_TEMP, {16'h0000, tt});
		rd(pmr_pkg::ADR_CURRENT, {8'h00, cc, 4'h0});
		rd(pmr_pkg::ADR_POWER, {8'h00, pp});
		rd(pmr_pkg::ADR_ENERGY, exp_e[31:0]);
		rd(pmr_pkg::ADR_ENERGY_HI, {24'h0, exp_e[39:32]});
		rd(pmr_pkg::ADR_CHARGE, exp_c[31:0]);
		rd(pmr_pkg::ADR_CHARGE_HI, {24'h0, exp_c[39:32]});
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 5; i <= 16; i++)
			if (i < 11 || i > 13)
				rd(8'(i * 4), 32'h0);
		dg(32'h0000_0001);
		wb(1'b1, pmr_pkg::ADR_POWER, 32'hFFFF_FFFF);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rd(pmr_pkg::ADR_POWER, 32'h0);
		`CHK("irq", 1'b0, irq)
		$display("test reset done");
		conv(20'h1_2345, 16'h8123, 20'hF_EDCB, 24'hAB_CDEF);
		conv(20'h8_0000, 16'h7FFF, 20'h0_0010, 24'h00_0001);
		$display("test results done");
		for (n = 0; exp_e[40] == 1'b0; n++)
			exp_e = exp_e + 41'(24'hFF_FFFF);
		exp_e[40] = 1'b0;
		u_src.convert(20'h0, 16'h0, 20'h0, 24'hFF_FFFF, 6'h00, n);
		dg(32'h0000_0803);
		rd(pmr_pkg::ADR_ENERGY, exp_e[31:0]);
		dg(32'h0000_0003);
		$display("test overflow done");
		u_src.start();
		wb(1'b1, pmr_pkg::ADR_IRQ_STATUS, 32'h0000_000F);
		cv(6'h00);
		rd(pmr_pkg::ADR_IRQ_STATUS, 32'h0000_0001);
		wb(1'b1, pmr_pkg::ADR_IRQ_MASK, 32'h0);
		irq0 = irq;
		wb(1'b1, pmr_pkg::ADR_IRQ_MASK, 32'h0000_000F);
		`CHK("irq mask", 1'b1, irq0 ^ irq)
		wb(1'b1, pmr_pkg::ADR_IRQ_STATUS, 32'h0000_0001);
		rd(pmr_pkg::ADR_IRQ_STATUS, 32'h0);
		`CHK("irq clear", 1'b0, irq)
		$display("test interrupt done");
		wb(1'b1, pmr_pkg::ADR_DIAG, 32'h0);
		u_src.start();
		u_src.raw(6'h01);
		oe_is(1'b1);
		dg(32'h0000_0005);
		u_src.raw(6'h00);
		oe_is(1'b0);
		cv(6'h3F);
		dg(32'h0000_0003);
		wb(1'b1, pmr_pkg::ADR_DIAG, 32'h0000_2000);
		u_src.start();
		u_src.raw(6'h3F);
		dg(32'h0000_2001);
		cv(6'h02);
		oe_is(1'b1);
		dg(32'h0000_200B);
		cv(6'h00);
		oe_is(1'b0);
		$display("test compare done");
		wb(1'b1, pmr_pkg::ADR_DIAG, 32'h0000_4000);
		u_src.start();
		oe_is(1'b0);
		cv(6'h00);
		oe_is(1'b1);
		u_src.start();
		oe_is(1'b0);
		wb(1'b1, pmr_pkg::ADR_DIAG, 32'h0000_8000);
		u_src.raw(6'h01);
		u_src.raw(6'h00);
		oe_is(1'b1);
		dg(32'h0000_8005);
		oe_is(1'b0);
		dg(32'h0000_8001);
		cv(6'h00);
		dg(32'h0000_8003);
		dg(32'h0000_8001);
		cv(6'h00);
		u_src.start();
		dg(32'h0000_8001);
		$display("test latch done");
		wb(1'b1, pmr_pkg::ADR_DIAG, 32'h0000_1000);
		oe_is(1'b1);
		u_src.raw(6'h01);
		oe_is(1'b0);
		`CHK("alert", 1'b0, alert)
		u_src.raw(6'h00);
		oe_is(1'b1);
		// Control byte not enabled: the write must leave polarity alone
		sel <= 4'hD;
		wb(1'b1, pmr_pkg::ADR_DIAG, 32'h0000_E000);
		sel <= 4'hF;
		dg(32'h0000_1001);
		$display("test polarity done");
		test_done();
	end
endmodule // pmr_monitor_regs_tb_top
`default_nettype wire
